/* File: core/tnr_consts.svh */
// register offsets, field positions, reset values and limits
`ifndef TNR_CONSTS_SVH
`define TNR_CONSTS_SVH

// ****************************************************
// register offsets (byte addresses on the plain port)
// ****************************************************
`define TNR_A_TCFG 8'h0B
`define TNR_A_FREQ_HOLD 8'h0C
`define TNR_A_PH_HOLD 8'h0D
`define TNR_A_FREQ_STB 8'h0E
`define TNR_A_PH_STB 8'h0F
`define TNR_A_RSC 8'h10
`define TNR_A_STATUS 8'h11
`define TNR_A_FREQ_ACT 8'h12
`define TNR_A_PH_ACT 8'h13

// ****************************************************
// field positions
// ****************************************************
`define TNR_FREQ_MSB 31
`define TNR_PH_MSB 7
`define TNR_RSC_DLY_MSB 11
`define TNR_RSC_DLY_LSB 4
`define TNR_RSC_BYP 3
`define TNR_RSC_MODE_MSB 2
`define TNR_TCFG_SYNC 5
`define TNR_TCFG_LOAD 0

// ****************************************************
// reset values
// ****************************************************
`define TNR_RST_FREQ 32'h0000_0000
`define TNR_RST_PH 8'h00
`define TNR_RST_DLY 8'h10
`define TNR_RST_BYP 1'b1
`define TNR_RST_MODE 3'h1

// ****************************************************
// timing counts in back-end clocks
// ****************************************************
`define TNR_DLY_MIN 8'h02
`define TNR_DLY_BUF 8'h05
`define TNR_DLY_SER 8'h10

`endif

/* File: core/tnr_pkg.sv */
// types shared by the timing oscillator and resampler control
package tnr_pkg;

   // ****************************************************
   // control words
   // ****************************************************
   // resampler control word fields
   typedef struct packed {
      logic [7:0] dly;   // pulse delay in clocks
      logic byp;         // section bypass
      logic [2:0] mode;  // {hb2, hb1, resampler}
   } tnr_rsc_t;

   // oscillator option bits
   typedef struct packed {
      logic sync_upd;    // sync input loads actives
      logic load_upd;    // frequency loads also zero feedback
   } tnr_tcfg_t;

   // output pulse sequencer state
   typedef enum logic {
      SEQ_IDLE,
      SEQ_RUN
   } tnr_seq_t;

   // ****************************************************
   // whole state of the control block
   // ****************************************************
   typedef struct packed {
      logic [31:0] freq_hold;
      logic [7:0] ph_hold;
      logic [31:0] freq_act;
      logic [7:0] ph_act;
      tnr_rsc_t rsc;
      tnr_tcfg_t tcfg;
      logic sync_d;      // last synced sync level
      logic acc_clr;     // feedback zero pulse
      tnr_seq_t seq;
      logic [7:0] cnt;   // clocks to next extra output
      logic [1:0] extra; // extra outputs still owed
      logic out_stb;
      logic cfg_err;
      logic [31:0] rdata;
   } tnr_state_t;

endpackage

/* File: core/tnr_sync2.sv */
// two flip-flop synchroniser for levels entering the clock domain
module tnr_sync2 #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);

   // ****************************************************
   // stages
   // ****************************************************
   // [0] is metastable-prone and feeds only [1]
   logic [1:0][W-1:0] st_reg;
   logic [1:0][W-1:0] st_next;

   // refuse an empty bus
   if (W < 1) begin : g_chk
      $error("tnr_sync2: W must be at least 1");
   end

   // shift one stage per clock
   always_comb begin
      st_next[0] = i_d;
      st_next[1] = st_reg[0];
   end

   // clear both stages on reset
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_q = st_reg[1];

endmodule

/* File: core/tnr_ctrl.sv */
// timing oscillator control words and resampler control
`include "tnr_consts.svh"

module tnr_ctrl #(
   parameter int ADDR_W = 8
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic i_timing_sync_in,
   input wire logic i_in_strobe,
   output logic [31:0] o_active_freq,
   output logic [7:0] o_active_phase,
   output logic o_acc_clear,
   output logic [7:0] o_pulse_delay,
   output logic o_bypass,
   output logic [2:0] o_mode,
   output logic o_out_strobe,
   output logic o_cfg_err
);

   // ****************************************************
   // elaboration checks
   // ****************************************************
   // the decoder compares against 8-bit offsets
   if (ADDR_W < 8) begin : g_chk
      $error("tnr_ctrl: ADDR_W must be at least 8");
   end

   // ****************************************************
   // reset value of the whole state
   // ****************************************************
   localparam tnr_pkg::tnr_state_t ST_RST = '{
      freq_hold: `TNR_RST_FREQ,
      ph_hold: `TNR_RST_PH,
      freq_act: `TNR_RST_FREQ,
      ph_act: `TNR_RST_PH,
      rsc: '{
         dly: `TNR_RST_DLY,
         byp: `TNR_RST_BYP,
         mode: `TNR_RST_MODE
      },
      tcfg: '{sync_upd: 1'b0, load_upd: 1'b0},
      sync_d: 1'b0,
      acc_clr: 1'b0,
      seq: tnr_pkg::SEQ_IDLE,
      cnt: 8'h00,
      extra: 2'h0,
      out_stb: 1'b0,
      cfg_err: 1'b0,
      rdata: 32'h0000_0000
   };

   // ****************************************************
   // helper functions
   // ****************************************************
   // address decode against an 8-bit offset
   function automatic logic hit(
      input logic [ADDR_W-1:0] a,
      input logic [7:0] off
   );
      hit = (a == ADDR_W'(off));
   endfunction

   // filter mode codes the section can run
   function automatic logic mode_ok(input logic [2:0] m);
      case (m)
         3'h1: mode_ok = 1'b1;  // resampler only
         3'h2: mode_ok = 1'b1;  // first halfband
         3'h3: mode_ok = 1'b1;  // resampler + first
         3'h6: mode_ok = 1'b1;  // both halfbands
         3'h7: mode_ok = 1'b1;  // all three
         default: mode_ok = 1'b0;
      endcase
   endfunction

   // extra outputs per input for a mode
   function automatic logic [1:0] extras(input logic [2:0] m);
      case (m[2:1])
         2'h3: extras = 2'h3;   // interpolate by four
         2'h1: extras = 2'h1;   // interpolate by two
         default: extras = 2'h0;
      endcase
   endfunction

   // software must never program 0 or 1; rather than let
   // the counter wrap for 255 clocks the sequencer clamps
   // delay with illegal 0 and 1 forced up to the floor
   function automatic logic [7:0] safe_dly(input logic [7:0] d);
      safe_dly = (d < `TNR_DLY_MIN) ? `TNR_DLY_MIN : d;
   endfunction

   // ****************************************************
   // reset release and sync input crossing
   // ****************************************************
   logic rst_n;   // synchronised reset, released on a clock
   logic sync_q;  // synced timing_sync_in level

   // hold reset low two clocks after the pin rises
   tnr_sync2 #(
      .W(1)
   ) u_rst_sync (
      .i_clk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_d(1'b1),
      .o_q(rst_n)
   );

   // a pulse shorter than one clock period may be
   // missed entirely; hold the pin high two clocks
   // the sync pin is asynchronous to the back-end clock
   tnr_sync2 #(
      .W(1)
   ) u_timing_sync (
      .i_clk(i_mclk),
      .i_rst_n(rst_n),
      .i_d(i_timing_sync_in),
      .o_q(sync_q)
   );

   // ****************************************************
   // state registers
   // ****************************************************
   // one packed struct holds every flop but the synchroniser stages, so the reset
   // value and the next-state copy can never drift apart
   tnr_pkg::tnr_state_t st_reg;  // registered state
   tnr_pkg::tnr_state_t st_next; // next state

   // strobes and decoded events of this cycle
   logic wr_freq_stb;
   logic wr_ph_stb;
   logic sync_load;
   logic [7:0] dly_eff;
   logic [31:0] status;

   // ****************************************************
   // next-state logic
   // ****************************************************
   always_comb begin
      st_next = st_reg;
      st_next.acc_clr = 1'b0;
      st_next.out_stb = 1'b0;
      st_next.rdata = 32'h0000_0000;

      // strobe writes carry no data at all
      wr_freq_stb = i_wr && hit(i_addr, `TNR_A_FREQ_STB);
      wr_ph_stb = i_wr && hit(i_addr, `TNR_A_PH_STB);

      // rising edge of the synced sync level; the first
      // stage stays private to the synchroniser
      st_next.sync_d = sync_q;
      sync_load = sync_q && !st_reg.sync_d
         && st_reg.tcfg.sync_upd;

      // ---------- holding and control writes ----------
      // a hold write never disturbs the active words; the
      // oscillator keeps running on the old pair meanwhile
      if (i_wr) begin
         if (hit(i_addr, `TNR_A_FREQ_HOLD)) begin
            // whole word, msb at bit 31
            st_next.freq_hold =
               i_wdata[`TNR_FREQ_MSB:0];
         end
         if (hit(i_addr, `TNR_A_PH_HOLD)) begin
            // only the low byte is stored
            st_next.ph_hold = i_wdata[`TNR_PH_MSB:0];
         end
         if (hit(i_addr, `TNR_A_RSC)) begin
            st_next.rsc.dly = i_wdata[`TNR_RSC_DLY_MSB:
               `TNR_RSC_DLY_LSB];
            st_next.rsc.byp = i_wdata[`TNR_RSC_BYP];
            st_next.rsc.mode =
               i_wdata[`TNR_RSC_MODE_MSB:0];
         end
         if (hit(i_addr, `TNR_A_TCFG)) begin
            st_next.tcfg.sync_upd = i_wdata[`TNR_TCFG_SYNC];
            st_next.tcfg.load_upd = i_wdata[`TNR_TCFG_LOAD];
         end
      end

      // ---------- holding to active transfers ----------
      // a sync load takes the holding value from before a
      // write landing in the same cycle
      if (wr_freq_stb || sync_load) begin
         st_next.freq_act = st_reg.freq_hold;
      end
      if (wr_ph_stb || sync_load) begin
         st_next.ph_act = st_reg.ph_hold;
      end

      // restart from a known phase on a frequency load;
      // a phase strobe alone does not restart
      if ((wr_freq_stb || sync_load)
            && st_reg.tcfg.load_upd) begin
         st_next.acc_clr = 1'b1;
      end

      // ---------- configuration check ----------
      // a running section needs a legal mode and delay;
      // a bypassed section ignores both, so cfg_err stays low
      st_next.cfg_err = !st_reg.rsc.byp
         && (!mode_ok(st_reg.rsc.mode)
         || st_reg.rsc.dly < `TNR_DLY_MIN);

      // ---------- output pulse sequencer ----------
      dly_eff = safe_dly(st_reg.rsc.dly);
      case (st_reg.seq)
         tnr_pkg::SEQ_IDLE: begin
            if (i_in_strobe) begin
               // an input while bypassed or without
               // interpolation gives only this output
               // first output follows the input one clock later
               st_next.out_stb = 1'b1;
               if (!st_reg.rsc.byp
                     && mode_ok(st_reg.rsc.mode)
                     && extras(st_reg.rsc.mode) != 2'h0) begin
                  st_next.extra = extras(st_reg.rsc.mode);
                  st_next.cnt = dly_eff;
                  st_next.seq = tnr_pkg::SEQ_RUN;
               end
            end
         end
         tnr_pkg::SEQ_RUN: begin
            if (i_in_strobe) begin
               // a new input preempts the owed extras,
               // and restarts the sequence just as an input in idle does
               st_next.out_stb = 1'b1;
               st_next.extra = extras(st_reg.rsc.mode);
               st_next.cnt = dly_eff;
               if (st_reg.rsc.byp
                     || extras(st_reg.rsc.mode) == 2'h0) begin
                  st_next.seq = tnr_pkg::SEQ_IDLE;
               end
            end else if (st_reg.cnt == 8'h01) begin
               // an extra output, delay clocks after the last
               st_next.out_stb = 1'b1;
               st_next.extra = st_reg.extra - 2'h1;
               st_next.cnt = dly_eff;
               if (st_reg.extra == 2'h1) begin
                  st_next.seq = tnr_pkg::SEQ_IDLE;
               end
            end else begin
               st_next.cnt = st_reg.cnt - 8'h01;
            end
         end
         default: begin
            // recover an impossible code to idle
            st_next.seq = tnr_pkg::SEQ_IDLE;
            st_next.extra = 2'h0;
            st_next.cnt = 8'h00;
         end
      endcase

      // ---------- status word ----------
      // low-delay warnings help software spot bad values;
      // bit 4 shows a sequence still owes extra outputs,
      // so software can poll it before changing the delay
      status = {
         27'h000_0000,
         st_reg.seq == tnr_pkg::SEQ_RUN,
         st_reg.rsc.dly < `TNR_DLY_SER,
         st_reg.rsc.dly < `TNR_DLY_BUF,
         st_reg.rsc.dly < `TNR_DLY_MIN,
         !mode_ok(st_reg.rsc.mode)
      };

      // ---------- read path ----------
      // data stands only in the cycle after the read;
      // unmapped and strobe offsets read as zero;
      // reads have no side effects, so polling is safe
      if (i_rd) begin
         if (hit(i_addr, `TNR_A_FREQ_HOLD)) begin
            st_next.rdata = st_reg.freq_hold;
         end else if (hit(i_addr, `TNR_A_PH_HOLD)) begin
            st_next.rdata = {24'h00_0000, st_reg.ph_hold};
         end else if (hit(i_addr, `TNR_A_RSC)) begin
            st_next.rdata = {20'h0_0000, st_reg.rsc};
         end else if (hit(i_addr, `TNR_A_TCFG)) begin
            st_next.rdata = {26'h000_0000,
               st_reg.tcfg.sync_upd, 4'h0,
               st_reg.tcfg.load_upd};
         end else if (hit(i_addr, `TNR_A_STATUS)) begin
            st_next.rdata = status;
         end else if (hit(i_addr, `TNR_A_FREQ_ACT)) begin
            st_next.rdata = st_reg.freq_act;
         end else if (hit(i_addr, `TNR_A_PH_ACT)) begin
            st_next.rdata = {24'h00_0000, st_reg.ph_act};
         end else begin
            st_next.rdata = 32'h0000_0000;
         end
      end
   end

   // ****************************************************
   // state register
   // ****************************************************
   // the synchronised reset keeps the release away from
   // the clock edge, so no flop sees a half-released reset
   // every update lands on the back-end clock edge
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= ST_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************************
   // outputs, straight from the state register
   // ****************************************************
   assign o_rdata = st_reg.rdata;
   assign o_active_freq = st_reg.freq_act;   // to the oscillator
   assign o_active_phase = st_reg.ph_act;
   assign o_acc_clear = st_reg.acc_clr;      // one-clock pulse
   assign o_pulse_delay = st_reg.rsc.dly;
   assign o_bypass = st_reg.rsc.byp;
   assign o_mode = st_reg.rsc.mode;
   assign o_out_strobe = st_reg.out_stb;
   assign o_cfg_err = st_reg.cfg_err;

endmodule

/* File: test/tnr_ctrl_asserts.sv */
// port-level checks of the timing and resampler control block
`include "tnr_consts.svh"
module tnr_ctrl_asserts #(
   parameter int ADDR_W = 8
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic i_timing_sync_in,
   input wire logic i_in_strobe,
   input wire logic [31:0] o_active_freq,
   input wire logic [7:0] o_active_phase,
   input wire logic o_acc_clear,
   input wire logic [7:0] o_pulse_delay,
   input wire logic o_bypass,
   input wire logic [2:0] o_mode,
   input wire logic o_out_strobe,
   input wire logic o_cfg_err
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************
   // strobe decode
   // ****************************************************
   // strobe writes decoded here so the properties stay short
   logic fstb;
   logic pstb;
   assign fstb = i_wr && (i_addr == `TNR_A_FREQ_STB);
   assign pstb = i_wr && (i_addr == `TNR_A_PH_STB);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // ****************************************************
   // properties
   // ****************************************************
   a_rdata_quiet: assert property (
      !$past(i_rd) |-> o_rdata == 32'h0000_0000)
      else $error("read data seen without a read");
   a_freq_load_cause: assert property (
      $changed(o_active_freq) |-> $past(fstb) || $past(i_timing_sync_in, 3))
      else $error("active frequency moved without a load");
   a_phase_load_cause: assert property (
      $changed(o_active_phase) |-> $past(pstb) || $past(i_timing_sync_in, 3))
      else $error("active phase moved without a load");
   a_clear_cause: assert property (
      o_acc_clear |-> $past(fstb) || $past(i_timing_sync_in, 3))
      else $error("feedback clear without a load");
   a_out_first: assert property (
      i_in_strobe |=> o_out_strobe)
      else $error("no output one cycle after an input");
   a_extra_cause: assert property (
      o_out_strobe && !$past(i_in_strobe)
      |-> !$past(o_bypass) && $past(o_mode[1]))
      else $error("extra output while bypassed or not interpolating");
   a_mode_err: assert property (
      $past(!o_bypass && o_mode == 3'h0) |-> o_cfg_err)
      else $error("zero mode not flagged");
   a_delay_err: assert property (
      $past(!o_bypass && o_pulse_delay < 8'h02) |-> o_cfg_err)
      else $error("short pulse delay not flagged");
endmodule
bind tnr_ctrl tnr_ctrl_asserts #(.ADDR_W(ADDR_W)) u_chk (
   .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_timing_sync_in(i_timing_sync_in), .i_in_strobe(i_in_strobe),
   .o_active_freq(o_active_freq), .o_active_phase(o_active_phase),
   .o_acc_clear(o_acc_clear), .o_pulse_delay(o_pulse_delay),
   .o_bypass(o_bypass), .o_mode(o_mode), .o_out_strobe(o_out_strobe),
   .o_cfg_err(o_cfg_err));

/* File: test/tnr_host_model.sv */
// processor model that writes and reads the control words
module tnr_host_model (
   input wire logic i_mclk,
   input wire logic [31:0] i_rdata,
   output logic [7:0] o_addr,
   output logic [31:0] o_wdata,
   output logic o_wr,
   output logic o_rd
);
   timeunit 1ns;
   timeprecision 1ps;
   // bus idle at time zero
   initial begin
      o_addr = 8'h00;
      o_wdata = 32'h0000_0000;
      o_wr = 1'h0;
      o_rd = 1'h0;
   end
   // one-cycle write; released lines flip so stale values never match
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'h1;
      @(posedge i_mclk);
      o_wr <= 1'h0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask
   // one-cycle read; data exist only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_mclk);
      o_addr <= a;
      o_rd <= 1'h1;
      @(posedge i_mclk);
      o_rd <= 1'h0;
      o_addr <= ~a;
      #1;
      d = i_rdata;
   endtask
endmodule

/* File: test/tnr_ctrl_test.sv */
// self-checking bench of the timing oscillator and resampler control
`include "tnr_consts.svh"
module tnr_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk, i_rst_n, i_wr, i_rd, i_timing_sync_in, i_in_strobe;
   logic [7:0] i_addr, o_active_phase, o_pulse_delay;
   logic [31:0] i_wdata, o_rdata, o_active_freq;
   logic o_acc_clear, o_bypass, o_out_strobe, o_cfg_err, b;
   logic [2:0] o_mode;
   logic [2:0] modes [6] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h7, 3'h7};
   logic [31:0] seed = 32'h8615;
   logic [31:0] f, p, v, ef, ep;
   int err_count = 0;
   int compares = 0;
   int n, last, d, e;
   // lfsr draws, repeatable from the fixed seed
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   // extra outputs owed per input: only interpolation makes them
   function automatic int extras(input logic byp, input logic [2:0] m);
      if (byp || !m[1]) begin
         return 0;
      end
      return m[2] ? 3 : 1;
   endfunction
   task automatic chk(input string nm, input logic [31:0] x,
                      input logic [31:0] g);
      compares++;
      if (g !== x) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ****************************************************
   // clock, design and processor model
   // ****************************************************
   initial begin
      i_mclk = 1'h0;
      forever #20 i_mclk = ~i_mclk;
   end
   tnr_ctrl i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .i_timing_sync_in(i_timing_sync_in), .i_in_strobe(i_in_strobe),
      .o_active_freq(o_active_freq), .o_active_phase(o_active_phase),
      .o_acc_clear(o_acc_clear), .o_pulse_delay(o_pulse_delay),
      .o_bypass(o_bypass), .o_mode(o_mode), .o_out_strobe(o_out_strobe),
      .o_cfg_err(o_cfg_err));
   tnr_host_model host (.i_mclk(i_mclk), .i_rdata(o_rdata), .o_addr(i_addr),
      .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
   // hang guard: a run this long means something stalled
   initial begin
      repeat (20000) @(posedge i_mclk);
      err_count++;
      give_verdict();
   end
   // ****************************************************
   // main sequence
   // ****************************************************
   initial begin
      i_rst_n = 1'h0;
      i_timing_sync_in = 1'h0;
      i_in_strobe = 1'h0;
      ef = 32'h0000_0000;
      ep = 32'h0000_0000;
      repeat (5) @(posedge i_mclk);
      i_rst_n <= 1'h1;
      repeat (3) @(posedge i_mclk);
      host.rd(`TNR_A_RSC, v);
      chk("resampler word", 32'h0000_0109, v);
      host.rd(8'h20, v);
      chk("unmapped read", 32'h0000_0000, v);
      // holds must not leak into actives until the strobes
      for (int i = 0; i < 4; i++) begin
         f = rnd();
         p = rnd();
         host.wr(`TNR_A_TCFG, {31'h0000_0000, f[0]});
         host.rd(`TNR_A_TCFG, v);
         chk("option bits", {31'h0000_0000, f[0]}, v);
         host.wr(`TNR_A_FREQ_HOLD, f);
         host.wr(`TNR_A_PH_HOLD, p);
         #1;
         chk("freq held", ef, o_active_freq);
         chk("phase held", ep, {24'h00_0000, o_active_phase});
         host.rd(`TNR_A_FREQ_HOLD, v);
         chk("freq hold", f, v);
         host.rd(`TNR_A_PH_HOLD, v);
         chk("phase hold", {24'h00_0000, p[7:0]}, v);
         host.wr(`TNR_A_FREQ_STB, rnd());
         #1;
         ef = f;
         chk("freq loaded", ef, o_active_freq);
         chk("clear on freq", {31'h0000_0000, f[0]}, o_acc_clear);
         host.rd(`TNR_A_FREQ_ACT, v);
         chk("freq active", f, v);
         host.wr(`TNR_A_PH_STB, rnd());
         #1;
         ep = {24'h00_0000, p[7:0]};
         chk("phase loaded", ep, {24'h00_0000, o_active_phase});
         chk("clear on phase", 32'h0000_0000, o_acc_clear);
         host.rd(`TNR_A_PH_ACT, v);
         chk("phase active", ep, v);
         host.rd(`TNR_A_FREQ_STB, v);
         chk("strobe read", 32'h0000_0000, v);
      end
      $display("done: holding registers and strobes");
      // sync pulse ignored without the option, loads both with it
      f = rnd();
      p = rnd();
      host.wr(`TNR_A_FREQ_HOLD, f);
      host.wr(`TNR_A_PH_HOLD, p);
      for (int s = 0; s < 2; s++) begin
         host.wr(`TNR_A_TCFG, {26'h000_0000, s[0], 5'h01});
         @(posedge i_mclk);
         i_timing_sync_in <= 1'h1;
         @(posedge i_mclk);
         i_timing_sync_in <= 1'h0;
         repeat (2) @(posedge i_mclk);
         #1;
         chk("sync clear", s, o_acc_clear);
         if (s == 1) begin
            ef = f;
            ep = {24'h00_0000, p[7:0]};
         end
         chk("sync freq", ef, o_active_freq);
         chk("sync phase", ep, {24'h00_0000, o_active_phase});
      end
      $display("done: sync loading");
      // every legal mode, then bypass; count and place the outputs
      for (int m = 0; m < 6; m++) begin
         d = 5 + int'(rnd() % 16);
         b = (m == 5);
         e = extras(b, modes[m]);
         host.wr(`TNR_A_RSC, {20'h0_0000, d[7:0], b, modes[m]});
         @(posedge i_mclk);
         i_in_strobe <= 1'h1;
         @(posedge i_mclk);
         i_in_strobe <= 1'h0;
         n = 0;
         last = 0;
         for (int c = 1; c < 4 * d + 4; c++) begin
            #1;
            if (o_out_strobe === 1'h1) begin
               n++;
               last = c;
            end
            @(posedge i_mclk);
         end
         chk("output count", e + 1, n);
         chk("last output", 1 + e * d, last);
         chk("delay field", d, {24'h00_0000, o_pulse_delay});
         chk("mode field", modes[m], o_mode);
         chk("bypass field", b, o_bypass);
         chk("no error", 32'h0000_0000, o_cfg_err);
      end
      $display("done: resampler outputs");
      // invalid settings are flagged one cycle after the write
      host.wr(`TNR_A_RSC, 32'h0000_0011);
      repeat (2) @(posedge i_mclk);
      #1;
      chk("delay error", 32'h0000_0001, o_cfg_err);
      host.rd(`TNR_A_STATUS, v);
      chk("low delay status", 32'h0000_000E, v);
      host.wr(`TNR_A_RSC, 32'h0000_0100);
      repeat (2) @(posedge i_mclk);
      #1;
      chk("mode error", 32'h0000_0001, o_cfg_err);
      host.rd(`TNR_A_STATUS, v);
      chk("bad mode status", 32'h0000_0001, v);
      $display("done: invalid settings");
      give_verdict();
   end
endmodule
